// ### rtl/odc_top.sv
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module odc_top (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write
	input wire logic [odc_pkg::ODC_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [odc_pkg::ODC_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// display ram side
	input wire logic page_mode,
	input wire logic [6:0] wr_col,
	input wire logic [odc_pkg::ODC_COLS-1:0] ram_row_bits,
	output logic [6:0] wr_col_phys_q,
	output logic [2:0] page_start_q,
	output logic [5:0] ram_row_addr_q,
	// panel drive
	output logic [odc_pkg::ODC_COLS-1:0] seg_pix_q,
	output logic [5:0] disp_com_q,
	output logic com_active_q,
	output logic com_hiz_q,
	output logic [7:0] seg_drive_q,
	output logic reference_current_source_internal_q
);
	import odc_pkg::*;

	odc_state_t st_q;
	logic [7:0] op_q;
	logic [7:0] contrast_q;
	logic seg_remap_q, all_on_q, inverse_q, reference_current_source_sel_q, disp_on_q;
	logic com_remap_q;
	logic [5:0] mux_q, offset_q, start_q, scan_q, com_q;
	logic act_q;
	logic aw_got_q, w_got_q;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	logic cmd_fire;
	logic [7:0] cmd_byte;
	logic [odc_pkg::ODC_COLS-1:0] pix_d;

	function automatic logic takes_arg(input logic [7:0] op);
		takes_arg = op == ODC_OP_CONTRAST || op == ODC_OP_MUX ||
			op == ODC_OP_REFERENCE_CURRENT_SOURCE || op == ODC_OP_OFFSET;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = a == ODC_OFS_CMD || a == ODC_OFS_CTRL_STAT ||
			a == ODC_OFS_MAP_STAT;
	endfunction

	// write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= ODC_RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_got_q <= 1'b1;
				aw_q <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_got_q <= 1'b1;
				w_q <= wdata;
				ws_q <= wstrb;
				wready <= 1'b0;
			end
			if (aw_got_q && w_got_q && !bvalid) begin
				bvalid <= 1'b1;
				bresp <= aw_q == ODC_OFS_CMD ? ODC_RESP_OKAY : ODC_RESP_SLVERR;
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// command byte enters the interpreter once per write to ODC_OFS_CMD with wstrb bit 0 set
	assign cmd_fire = ce && aw_got_q && w_got_q && !bvalid &&
		aw_q == ODC_OFS_CMD && ws_q[0];
	assign cmd_byte = w_q[7:0];

	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= ODC_RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rresp <= mapped(araddr) ? ODC_RESP_OKAY : ODC_RESP_SLVERR;
				case (araddr)
					ODC_OFS_CTRL_STAT: rdata <= {16'h0000, contrast_q,
						st_q == ODC_ST_ARG, page_mode, reference_current_source_sel_q, com_remap_q,
						disp_on_q, inverse_q, all_on_q, seg_remap_q};
					ODC_OFS_MAP_STAT: rdata <= {2'h0, scan_q, 2'h0, start_q,
						2'h0, offset_q, 2'h0, mux_q};
					default: rdata <= 32'h0000_0000;
				endcase
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// opcode / argument sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ODC_ST_IDLE;
			op_q <= 8'h00;
		end else if (cmd_fire) begin
			case (st_q)
				ODC_ST_IDLE: begin
					op_q <= cmd_byte;
					st_q <= takes_arg(cmd_byte) ? ODC_ST_ARG : ODC_ST_IDLE;
				end
				ODC_ST_ARG: st_q <= ODC_ST_IDLE;
				default: st_q <= ODC_ST_IDLE;
			endcase
		end
	end

	// single-byte commands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seg_remap_q <= 1'b0;
			all_on_q <= 1'b0;
			inverse_q <= 1'b0;
			disp_on_q <= 1'b0;
			com_remap_q <= 1'b0;
			start_q <= ODC_RST_START;
			page_start_q <= ODC_RST_PAGE;
		end else if (cmd_fire && st_q == ODC_ST_IDLE) begin
			case (cmd_byte)
				ODC_OP_SEG_NORM: seg_remap_q <= 1'b0;
				ODC_OP_SEG_REV: seg_remap_q <= 1'b1;
				ODC_OP_RESUME: all_on_q <= 1'b0;
				ODC_OP_ALL_ON: all_on_q <= 1'b1;
				ODC_OP_NORMAL: inverse_q <= 1'b0;
				ODC_OP_INVERSE: inverse_q <= 1'b1;
				ODC_OP_DISP_OFF: disp_on_q <= 1'b0;
				ODC_OP_DISP_ON: disp_on_q <= 1'b1;
				ODC_OP_COM_NORM: com_remap_q <= 1'b0;
				ODC_OP_COM_REV: com_remap_q <= 1'b1;
				default: begin
					if (cmd_byte[7:6] == ODC_OP_START_HI)
						start_q <= cmd_byte[5:0];
					if (cmd_byte[7:3] == ODC_OP_PAGE_HI && page_mode)
						page_start_q <= cmd_byte[2:0];
				end
			endcase
		end
	end

	// second byte of two-byte commands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			contrast_q <= ODC_RST_CONTRAST;
			mux_q <= ODC_RST_MUX;
			offset_q <= ODC_RST_OFFSET;
			reference_current_source_sel_q <= 1'b0;
		end else if (cmd_fire && st_q == ODC_ST_ARG) begin
			case (op_q)
				ODC_OP_CONTRAST:
					if (cmd_byte >= ODC_CONTRAST_MIN)
						contrast_q <= cmd_byte;
				ODC_OP_MUX:
					if (cmd_byte[5:0] >= ODC_MUX_MIN)
						mux_q <= cmd_byte[5:0];
				ODC_OP_REFERENCE_CURRENT_SOURCE: reference_current_source_sel_q <= cmd_byte[ODC_REFERENCE_CURRENT_SOURCE_BIT];
				ODC_OP_OFFSET: offset_q <= cmd_byte[5:0];
				default: offset_q <= offset_q;
			endcase
		end
	end

	// column steering for incoming ram writes; stored data untouched
	always_ff @(posedge aclk) begin
		if (!aresetn)
			wr_col_phys_q <= 7'h00;
		else if (ce)
			wr_col_phys_q <= seg_remap_q ? ODC_COL_MAX - wr_col : wr_col;
	end

	odc_map_if mif ();
	assign mif.common_output = scan_q;
	assign mif.remap = com_remap_q;
	assign mif.mux = mux_q;
	assign mif.offset = offset_q;
	assign mif.start = start_q;

	odc_row_map u_map (
		.m(mif.map)
	);

	// common scan: fetch row, then drive segments one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scan_q <= 6'h00;
			com_q <= 6'h00;
			act_q <= 1'b0;
			ram_row_addr_q <= 6'h00;
		end else if (ce) begin
			scan_q <= 6'(scan_q + 6'h01);
			com_q <= scan_q;
			act_q <= mif.active;
			ram_row_addr_q <= mif.row;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < ODC_COLS; gi++) begin : g_pix
			assign pix_d[gi] = disp_on_q && act_q &&
				(all_on_q || (ram_row_bits[gi] ^ inverse_q));
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seg_pix_q <= '0;
			disp_com_q <= 6'h00;
			com_active_q <= 1'b0;
			com_hiz_q <= 1'b1;
			seg_drive_q <= 8'h00;
			reference_current_source_internal_q <= 1'b0;
		end else if (ce) begin
			seg_pix_q <= pix_d;
			disp_com_q <= com_q;
			com_active_q <= act_q && disp_on_q;
			com_hiz_q <= !disp_on_q;
			seg_drive_q <= disp_on_q ? contrast_q : 8'h00;
			reference_current_source_internal_q <= reference_current_source_sel_q && disp_on_q;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_CONTRAST: assert property (
		cmd_fire && st_q == ODC_ST_ARG && op_q == ODC_OP_CONTRAST &&
		cmd_byte != 8'h00 ##1 ce && disp_on_q |=> seg_drive_q ==
		$past(cmd_byte, 2)) else $error("contrast not applied");
	AST_SEG_REMAP: assert property (
		cmd_fire && st_q == ODC_ST_IDLE && cmd_byte == ODC_OP_SEG_REV
		|=> seg_remap_q) else $error("segment remap not set");
	AST_WR_COL: assert property (
		ce && seg_remap_q |=> wr_col_phys_q == 7'(7'h7F - $past(wr_col)))
		else $error("write column not reversed");
	AST_ALL_ON: assert property (
		ce && all_on_q && disp_on_q && act_q |=> &seg_pix_q)
		else $error("forced on not lit");
	AST_RAM_PIX: assert property (
		ce && !all_on_q && disp_on_q && act_q |=> seg_pix_q ==
		($past(ram_row_bits) ^ {128{$past(inverse_q)}}))
		else $error("pixel polarity wrong");
	AST_MUX: assert property (
		cmd_fire && st_q == ODC_ST_ARG && op_q == ODC_OP_MUX &&
		cmd_byte[5:0] >= 6'h0F |=> mux_q == $past(cmd_byte[5:0]))
		else $error("mux ratio not loaded");
	AST_REFERENCE_CURRENT_SOURCE: assert property (
		ce && reference_current_source_sel_q && !disp_on_q |=> !reference_current_source_internal_q)
		else $error("internal reference while off");
	AST_OFF: assert property (
		ce && !disp_on_q |=> seg_pix_q == '0 && com_hiz_q)
		else $error("display off not enforced");
	AST_PAGE: assert property (
		cmd_fire && st_q == ODC_ST_IDLE && page_mode &&
		cmd_byte[7:3] == 5'h16 |=> page_start_q == $past(cmd_byte[2:0]))
		else $error("page start not loaded");
	AST_COM_REV: assert property (
		cmd_fire && st_q == ODC_ST_IDLE && cmd_byte == ODC_OP_COM_REV
		##1 ce |=> ram_row_addr_q == 6'($past(mux_q) - $past(scan_q) +
		$past(offset_q) + $past(start_q))) else $error("scan not flipped");
	AST_OFFSET: assert property (
		cmd_fire && st_q == ODC_ST_ARG && op_q == ODC_OP_OFFSET
		|=> offset_q == $past(cmd_byte[5:0])) else $error("offset lost");
	AST_START: assert property (
		cmd_fire && st_q == ODC_ST_IDLE && cmd_byte[7:6] == 2'h1
		|=> start_q == $past(cmd_byte[5:0])) else $error("start line lost");

	COV_ON: cover property (cmd_fire && cmd_byte == ODC_OP_DISP_ON);
	COV_INV: cover property (inverse_q && disp_on_q && act_q);
	COV_MUX: cover property (mux_q == 6'h2F && com_remap_q);
	COV_RERR: cover property (rvalid && rresp == ODC_RESP_SLVERR);
endmodule // odc_top
`default_nettype wire

// ### rtl/odc_pkg.sv
package odc_pkg;
	// bus map
	localparam int ODC_ADDR_W = 8;
	localparam logic [7:0] ODC_OFS_CMD = 8'h00;
	localparam logic [7:0] ODC_OFS_CTRL_STAT = 8'h04;
	localparam logic [7:0] ODC_OFS_MAP_STAT = 8'h08;
	localparam logic [1:0] ODC_RESP_OKAY = 2'h0;
	localparam logic [1:0] ODC_RESP_SLVERR = 2'h2;
	// opcodes
	localparam logic [7:0] ODC_OP_CONTRAST = 8'h81;
	localparam logic [7:0] ODC_OP_SEG_NORM = 8'hA0;
	localparam logic [7:0] ODC_OP_SEG_REV = 8'hA1;
	localparam logic [7:0] ODC_OP_RESUME = 8'hA4;
	localparam logic [7:0] ODC_OP_ALL_ON = 8'hA5;
	localparam logic [7:0] ODC_OP_NORMAL = 8'hA6;
	localparam logic [7:0] ODC_OP_INVERSE = 8'hA7;
	localparam logic [7:0] ODC_OP_MUX = 8'hA8;
	localparam logic [7:0] ODC_OP_REFERENCE_CURRENT_SOURCE = 8'hAD;
	localparam logic [7:0] ODC_OP_DISP_OFF = 8'hAE;
	localparam logic [7:0] ODC_OP_DISP_ON = 8'hAF;
	localparam logic [4:0] ODC_OP_PAGE_HI = 5'h16;
	localparam logic [7:0] ODC_OP_COM_NORM = 8'hC0;
	localparam logic [7:0] ODC_OP_COM_REV = 8'hC8;
	localparam logic [7:0] ODC_OP_OFFSET = 8'hD3;
	localparam logic [1:0] ODC_OP_START_HI = 2'h1;
	// argument fields and limits
	localparam int ODC_REFERENCE_CURRENT_SOURCE_BIT = 4;
	localparam logic [7:0] ODC_CONTRAST_MIN = 8'h01;
	localparam logic [5:0] ODC_MUX_MIN = 6'h0F;
	// reset values, column count and sequencer states
	localparam logic [7:0] ODC_RST_CONTRAST = 8'h7F;
	localparam logic [5:0] ODC_RST_MUX = 6'h3F;
	localparam logic [5:0] ODC_RST_OFFSET = 6'h00;
	localparam logic [5:0] ODC_RST_START = 6'h00;
	localparam logic [2:0] ODC_RST_PAGE = 3'h0;
	localparam int ODC_COLS = 128;
	localparam logic [6:0] ODC_COL_MAX = 7'h7F;
	typedef enum logic [1:0] {
		ODC_ST_IDLE = 2'b01,
		ODC_ST_ARG = 2'b10
	} odc_state_t;
endpackage

// ### rtl/odc_map_if.sv
`timescale 1ns/1ps
`default_nettype none
interface odc_map_if;
	logic [5:0] common_output;
	logic remap;
	logic [5:0] mux;
	logic [5:0] offset;
	logic [5:0] start;
	logic [5:0] row;
	logic active;
	modport cfg (output common_output, remap, mux, offset, start, input row, active);
	modport map (input common_output, remap, mux, offset, start, output row, active);
endinterface
`default_nettype wire

// ### rtl/odc_row_map.sv
`timescale 1ns/1ps
`default_nettype none
module odc_row_map (
	odc_map_if.map m
);
	logic [5:0] line;
	logic [5:0] shifted;
	// reversed scan counts down from the last active line
	always_comb begin
		line = m.remap ? 6'(m.mux - m.common_output) : m.common_output;
		shifted = 6'(line + m.offset);
		m.active = shifted <= m.mux;
		m.row = 6'(shifted + m.start);
	end
endmodule // odc_row_map
`default_nettype wire

// ### bench/odc_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module odc_ram_model (
	// row lookup, answers in the same cycle
	input wire logic [5:0] row_addr,
	output logic [127:0] row_bits
);
	// each row carries its own index so a wrong fetch shows
	assign row_bits = {16{2'h2, row_addr}};
endmodule // odc_ram_model
`default_nettype wire

// ### bench/oled_display_control_commands_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module oled_display_control_commands_bench;
	import odc_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic ce = 1'h1;
	logic [2:0] prot = 3'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic page_mode = 1'h0;
	logic [6:0] wr_col = 7'h00;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [127:0] ram_row_bits, seg_pix_q;
	logic [6:0] wr_col_phys_q;
	logic [2:0] page_start_q;
	logic [5:0] ram_row_addr_q, disp_com_q;
	logic com_active_q, com_hiz_q, reference_current_source_internal_q;
	logic [7:0] seg_drive_q;
	int fail_count = 0;
	int compares = 0;
	logic [7:0] con = 8'h7F;
	logic [7:0] pop = 8'h00;
	logic [5:0] mux = 6'h3F;
	logic [5:0] off = 6'h00;
	logic [5:0] st = 6'h00;
	logic [2:0] pg = 3'h0;
	logic sr = 1'h0, ao = 1'h0, inv = 1'h0, on = 1'h0;
	logic cr = 1'h0, ir = 1'h0, pend = 1'h0;

	always #2.5 aclk = ~aclk;

	odc_top DUT (.aclk, .aresetn, .ce, .awaddr, .awprot(prot), .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arprot(prot), .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .page_mode, .wr_col, .ram_row_bits, .wr_col_phys_q,
		.page_start_q, .ram_row_addr_q, .seg_pix_q, .disp_com_q, .com_active_q,
		.com_hiz_q, .seg_drive_q, .reference_current_source_internal_q);
	odc_ram_model PM (.row_addr(ram_row_addr_q), .row_bits(ram_row_bits));

	function automatic logic [127:0] pat(input logic [5:0] a);
		return {16{2'h2, a}};
	endfunction

	function automatic logic [15:0] stat();
		return {con, pend, page_mode, ir, cr, on, inv, ao, sr};
	endfunction

	task automatic finish_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic ad, wd;
		ad = 1'h0;
		wd = 1'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awready && !ad) begin
				ad = 1'h1;
				awvalid <= 1'h0;
			end
			if (wready && !wd) begin
				wd = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask

	task automatic cmd(input logic [7:0] b);
		logic [1:0] r;
		logic [31:0] d;
		wr(ODC_OFS_CMD, b, 4'hF, r);
		if (pend) begin
			pend = 1'h0;
			case (pop)
				ODC_OP_CONTRAST: if (b != 8'h00) con = b;
				ODC_OP_MUX: if (b[5:0] >= ODC_MUX_MIN) mux = b[5:0];
				ODC_OP_REFERENCE_CURRENT_SOURCE: ir = b[ODC_REFERENCE_CURRENT_SOURCE_BIT];
				default: off = b[5:0];
			endcase
		end else if (b inside {ODC_OP_CONTRAST, ODC_OP_MUX, ODC_OP_REFERENCE_CURRENT_SOURCE,
			ODC_OP_OFFSET}) begin
			pend = 1'h1;
			pop = b;
		end else if (b[7:3] == ODC_OP_PAGE_HI) begin
			if (page_mode) pg = b[2:0];
		end else if (b[7:6] == ODC_OP_START_HI) begin
			st = b[5:0];
		end else begin
			case (b)
				ODC_OP_SEG_NORM, ODC_OP_SEG_REV: sr = b[0];
				ODC_OP_RESUME, ODC_OP_ALL_ON: ao = b[0];
				ODC_OP_NORMAL, ODC_OP_INVERSE: inv = b[0];
				ODC_OP_DISP_OFF, ODC_OP_DISP_ON: on = b[0];
				ODC_OP_COM_NORM, ODC_OP_COM_REV: cr = b[3];
				default: ;
			endcase
		end
		rd(ODC_OFS_CTRL_STAT, d, r);
		`CHK("status", stat(), d[15:0])
		`CHK("drive", on ? con : 8'h00, seg_drive_q)
		`CHK("hiz", !on, com_hiz_q)
		`CHK("reference_current_source", ir && on, reference_current_source_internal_q)
		`CHK("page", pg, page_start_q)
	endtask

	task automatic scan(input int n);
		logic [5:0] pa, l, pc;
		logic [127:0] px;
		@(negedge aclk);
		pa = ram_row_addr_q;
		pc = disp_com_q;
		repeat (n) begin
			@(negedge aclk);
			l = cr ? mux - disp_com_q : disp_com_q;
			px = ao ? {128{1'h1}} : inv ? ~pat(pa) : pat(pa);
			`CHK("com", 6'(pc + 6'h01), disp_com_q)
			`CHK("row", 6'(l + off + st), pa)
			`CHK("active", on && (6'(l + off) <= mux), com_active_q)
			if (com_active_q === 1'h1)
				`CHK("pix", px, seg_pix_q)
			else
				`CHK("dark", 128'h0, seg_pix_q)
			pa = ram_row_addr_q;
			pc = disp_com_q;
		end
	endtask

	initial begin
		#100000;
		fail_count++;
		finish_test();
	end

	initial begin
		logic [1:0] r;
		logic [31:0] d;
		logic [7:0] ops [12];
		logic [6:0] c;
		ops = '{8'hA1, 8'hA0, 8'hA5, 8'hA4, 8'hA7, 8'hA6, 8'hAF, 8'hAE,
			8'hC8, 8'hC0, 8'hE3, 8'hAF};
		void'($urandom(32'h1251146a));
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		rd(ODC_OFS_CTRL_STAT, d, r);
		`CHK("reset", {stat(), 2'h2}, {d[15:0], com_hiz_q, r[1]})
		wr(8'h0C, ODC_OP_DISP_ON, 4'hF, r);
		`CHK("bad wr", {ODC_RESP_SLVERR, 1'h1}, {r, com_hiz_q})
		rd(8'h0C, d, r);
		`CHK("bad rd", {ODC_RESP_SLVERR, 32'h0}, {r, d})
		wr(ODC_OFS_CMD, ODC_OP_DISP_ON, 4'hE, r);
		`CHK("strobe", 1'h1, com_hiz_q)
		foreach (ops[k]) cmd(ops[k]);
		for (int i = 0; i < 9; i++) begin
			cmd(ODC_OP_CONTRAST);
			cmd(i == 0 ? 8'h01 : i == 1 ? 8'hFF : i == 2 ? 8'h00 :
				8'($urandom_range(255, 1)));
		end
		cmd(ODC_OP_REFERENCE_CURRENT_SOURCE);
		cmd(8'h10);
		cmd(ODC_OP_DISP_OFF);
		cmd(ODC_OP_DISP_ON);
		cmd(ODC_OP_REFERENCE_CURRENT_SOURCE);
		cmd(8'hEF);
		page_mode <= 1'h1;
		for (int i = 0; i < 8; i++) cmd({ODC_OP_PAGE_HI, 3'(7 - i)});
		page_mode <= 1'h0;
		cmd(8'hB3);
		for (int i = 0; i < 4; i++) begin
			cmd(i[0] ? ODC_OP_SEG_REV : ODC_OP_SEG_NORM);
			c = 7'($urandom);
			@(posedge aclk);
			wr_col <= c;
			@(posedge aclk);
			@(negedge aclk);
			`CHK("col", sr ? ODC_COL_MAX - c : c, wr_col_phys_q)
		end
		scan(70);
		@(posedge aclk);
		ce <= 1'h0;
		@(negedge aclk);
		d[11:0] = {ram_row_addr_q, disp_com_q};
		repeat (4) @(negedge aclk);
		`CHK("freeze", d[11:0], {ram_row_addr_q, disp_com_q})
		@(posedge aclk);
		ce <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			cmd(ODC_OP_MUX);
			cmd(8'($urandom_range(63, 15)));
			cmd(ODC_OP_OFFSET);
			cmd(8'(64 - $urandom_range(63, 1)));
			cmd({ODC_OP_START_HI, 6'($urandom)});
			cmd(i[1] ? ODC_OP_COM_REV : ODC_OP_COM_NORM);
			cmd(i[0] ? ODC_OP_INVERSE : ODC_OP_NORMAL);
			cmd(i == 3 ? ODC_OP_ALL_ON : ODC_OP_RESUME);
			rd(ODC_OFS_MAP_STAT, d, r);
			`CHK("map resp", ODC_RESP_OKAY, r)
			`CHK("map", {mux, off, st}, {d[5:0], d[13:8], d[21:16]})
			scan(140);
		end
		cmd(ODC_OP_DISP_OFF);
		scan(70);
		finish_test();
	end
endmodule // oled_display_control_commands_bench
`default_nettype wire
